// >>> dpc_ctrl.sv
// phase compensation and loop configuration control with serial register port
`timescale 1ns/100ps

module dpc_ctrl #(
  parameter int MEAN_SCALE = 1  // measurement LSBs per 0.101 ns mean offset step
) (
  input  wire logic                   clock_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   spi_sclk_i,
  input  wire logic                   spi_cs_b_i,
  input  wire logic                   spi_sdi_i,
  output logic                        spi_sdo_o,
  output logic                        spi_sdo_oe_o,
  input  wire logic                   loop_locked_i,
  input  wire logic                   ref_switch_i,
  input  wire logic                   loop_update_i,
  input  wire logic                   at_freq_limit_i,
  input  wire dpc_pkg::dpc_fb_t       primary_fb_i,
  input  wire dpc_pkg::dpc_fb_t       secondary_fb_i,
  input  wire logic signed [15:0]     ref_phase_i,
  input  wire logic signed [15:0]     primary_phase_i,
  input  wire logic signed [15:0]     secondary_phase_i,
  input  wire logic                   sync_tick_8k_i,
  output dpc_pkg::dpc_loop_cfg_t      primary_cfg_o,
  output dpc_pkg::dpc_loop_cfg_t      secondary_cfg_o,
  output logic                        holdover_o,
  output logic signed [17:0]          phase_offset_o,
  output logic                        integral_limit_o,
  output logic [7:0]                  secondary_freq_sel_o,
  output logic [7:0]                  diff_output_sel_o,
  output logic                        secondary_digital_fb_o,
  output logic                        frame_sync_out_o,
  output logic                        multiframe_sync_out_o
);
  import dpc_pkg::*;

  // ----------------------------------------------------------------
  // serial port synchronisers and edge detection
  // ----------------------------------------------------------------
  logic       sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic       cs_s1_q, cs_s2_q;
  logic       sdi_s1_q, sdi_s2_q;
  logic       sclk_rise, sclk_fall, sel_active;
  logic [4:0] bit_cnt_q;
  logic [6:0] shift_q;
  logic [6:0] addr_q;
  logic       rd_q;
  logic [7:0] sdo_sh_q;
  logic       wr_q;
  logic [7:0] wr_data_q;
  logic [7:0] rd_data;
  logic [7:0] header;

  // pins are asynchronous: two flops before anything looks at them
  always_ff @(posedge clock_i) begin
    sclk_s1_q <= spi_sclk_i;
    sclk_s2_q <= sclk_s1_q;
    sclk_s3_q <= sclk_s2_q;
    cs_s1_q   <= spi_cs_b_i;
    cs_s2_q   <= cs_s1_q;
    sdi_s1_q  <= spi_sdi_i;
    sdi_s2_q  <= sdi_s1_q;
  end

  assign sclk_rise  = sclk_s2_q & ~sclk_s3_q;
  assign sclk_fall  = ~sclk_s2_q & sclk_s3_q;
  assign sel_active = ~cs_s2_q;
  assign header     = {shift_q, sdi_s2_q};

  // frame: r/w bit, 7 address bits, 8 data bits, msb first, sampled on rising sclk
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || !sel_active) begin
      bit_cnt_q <= 5'd0;
      shift_q   <= 7'd0;
      addr_q    <= 7'd0;
      rd_q      <= 1'b0;
      wr_q      <= 1'b0;
      wr_data_q <= 8'h00;
    end else begin
      wr_q <= 1'b0;
      if (sclk_rise && bit_cnt_q != 5'd16) begin
        shift_q   <= header[6:0];
        bit_cnt_q <= bit_cnt_q + 5'd1;
        if (bit_cnt_q == 5'd7) begin
          rd_q   <= header[7];
          addr_q <= header[6:0];
        end
        if (bit_cnt_q == 5'd15 && !rd_q) begin
          wr_q      <= 1'b1;
          wr_data_q <= header;
        end
      end
    end
  end

  // read data shifts out on falling sclk so it is stable at the next rise
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sdo_sh_q     <= 8'h00;
      spi_sdo_o    <= 1'b0;
      spi_sdo_oe_o <= 1'b0;
    end else begin
      spi_sdo_oe_o <= sel_active & rd_q & (bit_cnt_q >= 5'd8);
      if (sclk_rise && sel_active && bit_cnt_q == 5'd7) begin
        sdo_sh_q <= 8'h00;
      end else if (sel_active && rd_q && bit_cnt_q == 5'd8 && sclk_fall) begin
        spi_sdo_o <= rd_data[7];
        sdo_sh_q  <= {rd_data[6:0], 1'b0};
      end else if (sel_active && rd_q && bit_cnt_q > 5'd8 && sclk_fall) begin
        spi_sdo_o <= sdo_sh_q[7];
        sdo_sh_q  <= {sdo_sh_q[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] sec_fb_q, diff_out_q, bw_policy_q, bo_ctrl_q, mon_sel_q;
  logic [7:0] sec_freq_q, locked_bw_q, acq_bw_q, sec_low_gain_q, damp_low_q;
  logic [7:0] sec_pd2_q, pri_pd2_q, trim_lo_q, trim_hi_q, mean_ofs_q;
  logic [7:0] fine_loss_q, coarse_q, filter_aux_q;
  logic [15:0] status_q;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      sec_fb_q       <= RST_ZERO;
      diff_out_q     <= RST_ZERO;
      bw_policy_q    <= RST_ZERO;
      bo_ctrl_q      <= RST_BUILD_OUT_CTRL;
      mon_sel_q      <= RST_ZERO;
      sec_freq_q     <= RST_ZERO;
      locked_bw_q    <= RST_ZERO;
      acq_bw_q       <= RST_ZERO;
      sec_low_gain_q <= RST_ZERO;
      damp_low_q     <= RST_DAMP_LOW_GAIN;
      sec_pd2_q      <= RST_ZERO;
      pri_pd2_q      <= RST_ZERO;
      trim_lo_q      <= RST_ZERO;
      trim_hi_q      <= RST_ZERO;
      mean_ofs_q     <= RST_ZERO;
      fine_loss_q    <= RST_ZERO;
      coarse_q       <= RST_ZERO;
      filter_aux_q   <= RST_ZERO;
    end else if (wr_q) begin
      unique case (addr_q)
        OFS_SEC_FB_CFG:     sec_fb_q       <= wr_data_q;
        OFS_DIFF_OUT_SEL:   diff_out_q     <= wr_data_q;
        OFS_BW_POLICY:      bw_policy_q    <= wr_data_q;
        OFS_BUILD_OUT_CTRL: bo_ctrl_q      <= wr_data_q;
        OFS_PHASE_MON_SEL:  mon_sel_q      <= wr_data_q;
        OFS_SEC_OUT_FREQ:   sec_freq_q     <= wr_data_q;
        OFS_LOCKED_BW:      locked_bw_q    <= wr_data_q;
        OFS_ACQ_BW:         acq_bw_q       <= wr_data_q;
        OFS_SEC_LOW_GAIN:   sec_low_gain_q <= wr_data_q;
        OFS_DAMP_LOW_GAIN:  damp_low_q     <= wr_data_q;
        OFS_SEC_PD2_GAIN:   sec_pd2_q      <= wr_data_q;
        OFS_PRI_PD2_GAIN:   pri_pd2_q      <= wr_data_q;
        OFS_TRIM_LOW:       trim_lo_q      <= wr_data_q;
        OFS_TRIM_HIGH:      trim_hi_q      <= wr_data_q;
        OFS_MEAN_OFFSET:    mean_ofs_q     <= {2'b00, wr_data_q[5:0]};
        OFS_FINE_LOSS:      fine_loss_q    <= wr_data_q;
        OFS_COARSE_CFG:     coarse_q       <= wr_data_q;
        OFS_FILTER_AUX:     filter_aux_q   <= wr_data_q;
        default: ;  // status and unmapped addresses ignore writes
      endcase
    end
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    unique case (addr_q)
      OFS_SEC_FB_CFG:     rd_data = sec_fb_q;
      OFS_DIFF_OUT_SEL:   rd_data = diff_out_q;
      OFS_BW_POLICY:      rd_data = bw_policy_q;
      OFS_BUILD_OUT_CTRL: rd_data = bo_ctrl_q;
      OFS_PHASE_MON_SEL:  rd_data = mon_sel_q;
      OFS_SEC_OUT_FREQ:   rd_data = sec_freq_q;
      OFS_LOCKED_BW:      rd_data = locked_bw_q;
      OFS_ACQ_BW:         rd_data = acq_bw_q;
      OFS_SEC_LOW_GAIN:   rd_data = sec_low_gain_q;
      OFS_DAMP_LOW_GAIN:  rd_data = damp_low_q;
      OFS_SEC_PD2_GAIN:   rd_data = sec_pd2_q;
      OFS_PRI_PD2_GAIN:   rd_data = pri_pd2_q;
      OFS_TRIM_LOW:       rd_data = trim_lo_q;
      OFS_TRIM_HIGH:      rd_data = trim_hi_q;
      OFS_MEAN_OFFSET:    rd_data = mean_ofs_q;
      OFS_FINE_LOSS:      rd_data = fine_loss_q;
      OFS_COARSE_CFG:     rd_data = coarse_q;
      OFS_FILTER_AUX:     rd_data = filter_aux_q;
      OFS_STATUS_LOW:     rd_data = status_q[7:0];
      OFS_STATUS_HIGH:    rd_data = status_q[15:8];
      default:            rd_data = 8'h00;
    endcase
  end

  // phase monitor snapshot per loop update from the selected loop
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      status_q <= 16'h0000;
    end else if (loop_update_i) begin
      status_q <= mon_sel_q[BIT_MON_SECONDARY] ? secondary_phase_i : primary_phase_i;
    end
  end

  // ----------------------------------------------------------------
  // phase build-out sequencer
  // ----------------------------------------------------------------
  dpc_bo_state_t       bo_state_q;
  logic [5:0]          hold_cnt_q;
  logic                bo_en_prev_q;
  logic                bo_en, bo_freeze, bo_event;
  logic signed [17:0]  bo_offset_q;
  logic signed [17:0]  captured_q;
  logic signed [5:0]   mean_raw, mean_clamped;
  logic signed [17:0]  slew_step;
  logic [1:0]          eff_bw;

  assign bo_en     = bo_ctrl_q[BIT_BO_ENABLE];
  assign bo_freeze = bo_ctrl_q[BIT_BO_FREEZE];
  // a switch or a fresh enable in lock both trigger; freeze swallows either
  assign bo_event  = bo_en && !bo_freeze &&
                     (ref_switch_i || (!bo_en_prev_q && loop_locked_i));

  // mean offset clamped to the 1.4 ns span
  assign mean_raw     = $signed(mean_ofs_q[5:0]);
  assign mean_clamped = (mean_raw > MEAN_OFS_MAX)  ? MEAN_OFS_MAX :
                        (mean_raw < -MEAN_OFS_MAX) ? -MEAN_OFS_MAX : mean_raw;
  // wider bandwidth slews faster: step doubles per bandwidth code
  assign slew_step    = 18'sd1 <<< eff_bw;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      bo_en_prev_q <= 1'b1;  // matches reset enable so reset is no event
    end else begin
      bo_en_prev_q <= bo_en;
    end
  end

  // holdover, measure, apply; offset kept constant while frozen with build-out enabled
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      bo_state_q  <= BO_IDLE;
      hold_cnt_q  <= 6'd0;
      captured_q  <= 18'sd0;
      bo_offset_q <= 18'sd0;
      holdover_o  <= 1'b0;
    end else begin
      unique case (bo_state_q)
        BO_IDLE: begin
          if (bo_event) begin
            bo_state_q <= BO_HOLD;
            hold_cnt_q <= 6'(BO_HOLD_CYC - 1);
            holdover_o <= 1'b1;
          end else if (!bo_en && loop_locked_i && loop_update_i) begin
            if (bo_offset_q > slew_step) begin
              bo_offset_q <= bo_offset_q - slew_step;
            end else if (bo_offset_q < -slew_step) begin
              bo_offset_q <= bo_offset_q + slew_step;
            end else begin
              bo_offset_q <= 18'sd0;
            end
          end
        end
        BO_HOLD: begin
          if (hold_cnt_q == 6'd0) begin
            bo_state_q <= BO_MEASURE;
          end else begin
            hold_cnt_q <= hold_cnt_q - 6'd1;
          end
        end
        BO_MEASURE: begin
          // new reference phase plus the systematic mean correction
          captured_q <= 18'(ref_phase_i) +
                        18'(mean_clamped * MEAN_SCALE);
          bo_state_q <= BO_APPLY;
        end
        BO_APPLY: begin
          bo_offset_q <= captured_q;
          holdover_o  <= 1'b0;
          bo_state_q  <= BO_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // loop configuration, applied on loop update only
  // ----------------------------------------------------------------
  logic [2:0]         eff_damp, damp_max;
  logic [2:0]         pri_gain, sec_gain;
  logic               trim_allowed;
  logic signed [15:0] trim_val;
  dpc_loop_cfg_t      pri_cfg, sec_cfg;

  always_comb begin
    // automatic policy follows lock state; otherwise locked bandwidth only
    if (bw_policy_q[BIT_BW_AUTO] && !loop_locked_i) begin
      eff_bw = acq_bw_q[1:0];
    end else begin
      eff_bw = locked_bw_q[1:0];
    end
    if (eff_bw > BW_70HZ) begin
      eff_bw = BW_70HZ;  // unused code reads as widest setting
    end
    // lower bandwidths offer fewer damping factors
    unique case (eff_bw)
      BW_18HZ: damp_max = 3'd3;
      BW_35HZ: damp_max = 3'd4;
      default: damp_max = 3'd5;
    endcase
    eff_damp = damp_low_q[2:0];
    if (eff_damp == 3'd0) begin
      eff_damp = DAMP_DEFAULT;
    end else if (eff_damp > damp_max) begin
      eff_damp = damp_max;
    end
  end

  // detector gain per feedback type, one set per loop
  always_comb begin
    unique case (primary_fb_i)
      FB_DIGITAL:   pri_gain = pri_pd2_q[2:0];
      FB_ANALOG_HI: pri_gain = pri_pd2_q[6:4];
      default:      pri_gain = damp_low_q[2:0];
    endcase
    unique case (secondary_fb_i)
      FB_DIGITAL:   sec_gain = sec_pd2_q[2:0];
      FB_ANALOG_HI: sec_gain = sec_pd2_q[6:4];
      default:      sec_gain = sec_low_gain_q[2:0];
    endcase
  end

  always_comb begin
    pri_cfg.bandwidth             = eff_bw;
    pri_cfg.damping               = eff_damp;
    pri_cfg.pd2_enable            = pri_pd2_q[BIT_PD2_ENABLE];
    pri_cfg.pd2_gain              = pri_pd2_q[BIT_PD2_ENABLE] ? pri_gain : 3'd0;
    pri_cfg.fine_loss_enable      = fine_loss_q[BIT_FINE_ENABLE];
    pri_cfg.fine_loss_limit       = fine_loss_q[2:0];
    pri_cfg.coarse_loss_enable    = coarse_q[BIT_COARSE_LOSS];
    pri_cfg.coarse_capture_enable = coarse_q[BIT_COARSE_CAPT];
    pri_cfg.coarse_in_loop        = coarse_q[BIT_COARSE_LOOP];
    pri_cfg.coarse_range          = coarse_q[3:0];
    pri_cfg.noise_filter          = filter_aux_q[BIT_NOISE_FILTER];
    // secondary shares everything but its own detector gain
    sec_cfg                       = pri_cfg;
    sec_cfg.pd2_enable            = sec_pd2_q[BIT_PD2_ENABLE];
    sec_cfg.pd2_gain              = sec_pd2_q[BIT_PD2_ENABLE] ? sec_gain : 3'd0;
  end

  assign trim_allowed = !bo_freeze && !filter_aux_q[BIT_AUX_BUILD_OUT];
  assign trim_val     = $signed({trim_hi_q, trim_lo_q});

  // loop sees a new setting only between updates, never mid-accumulation
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      primary_cfg_o          <= '0;
      secondary_cfg_o        <= '0;
      phase_offset_o         <= 18'sd0;
      integral_limit_o       <= 1'b0;
      secondary_freq_sel_o   <= 8'h00;
      diff_output_sel_o      <= 8'h00;
      secondary_digital_fb_o <= 1'b0;
    end else if (loop_update_i) begin
      primary_cfg_o          <= pri_cfg;
      secondary_cfg_o        <= sec_cfg;
      // trim moves the feedback phase; the loop pulls the output after it
      phase_offset_o         <= trim_allowed ? bo_offset_q + 18'(trim_val)
                                             : bo_offset_q;
      integral_limit_o       <= bw_policy_q[BIT_INT_LIMIT] & at_freq_limit_i;
      secondary_freq_sel_o   <= sec_freq_q;
      diff_output_sel_o      <= diff_out_q;
      secondary_digital_fb_o <= sec_fb_q[6];
    end
  end

  // ----------------------------------------------------------------
  // frame and multiframe sync from the primary loop tick
  // ----------------------------------------------------------------
  logic [1:0] frame_cnt_q;

  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      frame_cnt_q           <= 2'd0;
      frame_sync_out_o      <= 1'b0;
      multiframe_sync_out_o <= 1'b0;
    end else begin
      frame_sync_out_o      <= sync_tick_8k_i;
      multiframe_sync_out_o <= sync_tick_8k_i && frame_cnt_q == 2'd0;
      if (sync_tick_8k_i) begin
        frame_cnt_q <= frame_cnt_q + 2'd1;
      end
    end
  end

endmodule

// >>> dpc_ctrl_sva.sv
// port assertions for the phase compensation controller
`timescale 1ns/100ps
module dpc_ctrl_sva (
  input wire logic                   clock_i,
  input wire logic                   rst_b_i,
  input wire logic                   loop_update_i,
  input wire logic                   at_freq_limit_i,
  input wire logic                   sync_tick_8k_i,
  input wire logic                   holdover_o,
  input wire logic signed [17:0]     phase_offset_o,
  input wire logic                   integral_limit_o,
  input wire dpc_pkg::dpc_loop_cfg_t primary_cfg_o,
  input wire logic [7:0]             secondary_freq_sel_o,
  input wire logic                   frame_sync_out_o,
  input wire logic                   multiframe_sync_out_o
);
  import dpc_pkg::*;
  // single domain, so one clock and one reset cut for all checks
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  a_hold_span: assert property ($rose(holdover_o) |-> holdover_o[*8] ##34 holdover_o ##1 !holdover_o)
    else $error("holdover span wrong");
  a_frame_follow: assert property (sync_tick_8k_i |=> frame_sync_out_o)
    else $error("frame sync missing");
  a_frame_cause: assert property (frame_sync_out_o |-> $past(sync_tick_8k_i))
    else $error("frame sync without tick");
  a_mframe_sub: assert property (multiframe_sync_out_o |-> frame_sync_out_o)
    else $error("multiframe off frame");
  a_cfg_update: assert property (!loop_update_i |=> $stable(primary_cfg_o))
    else $error("config moved off update");
  a_offset_update: assert property (!loop_update_i |=> $stable(phase_offset_o))
    else $error("offset moved off update");
  a_freq_update: assert property (!loop_update_i |=> $stable(secondary_freq_sel_o))
    else $error("frequency select moved off update");
  a_limit_cause: assert property (loop_update_i && !at_freq_limit_i |=> !integral_limit_o)
    else $error("integral limit without cause");
  a_limit_hold: assert property (!loop_update_i |=> $stable(integral_limit_o))
    else $error("integral limit moved off update");
endmodule

bind dpc_ctrl dpc_ctrl_sva dpc_ctrl_sva_i (.clock_i, .rst_b_i, .loop_update_i, .at_freq_limit_i,
  .sync_tick_8k_i, .holdover_o, .phase_offset_o, .integral_limit_o, .primary_cfg_o,
  .secondary_freq_sel_o, .frame_sync_out_o, .multiframe_sync_out_o);

// >>> dpc_pkg.sv
// constants, register map and carrier types of the phase compensation controller
package dpc_pkg;

  // ----------------------------------------------------------------
  // register offsets (serial port address space)
  // ----------------------------------------------------------------
  localparam logic [6:0] OFS_SEC_FB_CFG     = 7'h35;
  localparam logic [6:0] OFS_DIFF_OUT_SEL   = 7'h3a;
  localparam logic [6:0] OFS_BW_POLICY      = 7'h3b;
  localparam logic [6:0] OFS_BUILD_OUT_CTRL = 7'h48;
  localparam logic [6:0] OFS_PHASE_MON_SEL  = 7'h4b;
  localparam logic [6:0] OFS_SEC_OUT_FREQ   = 7'h64;
  localparam logic [6:0] OFS_LOCKED_BW      = 7'h67;
  localparam logic [6:0] OFS_ACQ_BW         = 7'h69;
  localparam logic [6:0] OFS_SEC_LOW_GAIN   = 7'h6a;
  localparam logic [6:0] OFS_DAMP_LOW_GAIN  = 7'h6b;
  localparam logic [6:0] OFS_SEC_PD2_GAIN   = 7'h6c;
  localparam logic [6:0] OFS_PRI_PD2_GAIN   = 7'h6d;
  localparam logic [6:0] OFS_TRIM_LOW       = 7'h70;
  localparam logic [6:0] OFS_TRIM_HIGH      = 7'h71;
  localparam logic [6:0] OFS_MEAN_OFFSET    = 7'h72;
  localparam logic [6:0] OFS_FINE_LOSS      = 7'h73;
  localparam logic [6:0] OFS_COARSE_CFG     = 7'h74;
  localparam logic [6:0] OFS_FILTER_AUX     = 7'h76;
  localparam logic [6:0] OFS_STATUS_LOW     = 7'h77;
  localparam logic [6:0] OFS_STATUS_HIGH    = 7'h78;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_BW_AUTO       = 7;  // bandwidth policy
  localparam int BIT_INT_LIMIT     = 3;  // integral limit at frequency limit
  localparam int BIT_BO_ENABLE     = 3;  // build-out enable
  localparam int BIT_BO_FREEZE     = 2;  // build-out freeze
  localparam int BIT_MON_SECONDARY = 4;  // phase monitor loop select
  localparam int BIT_PD2_ENABLE    = 7;  // detector gain enable
  localparam int BIT_FINE_ENABLE   = 7;
  localparam int BIT_COARSE_LOSS   = 7;
  localparam int BIT_COARSE_CAPT   = 6;
  localparam int BIT_COARSE_LOOP   = 5;
  localparam int BIT_NOISE_FILTER  = 7;
  localparam int BIT_AUX_BUILD_OUT = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BUILD_OUT_CTRL = 8'h08;  // build-out on
  localparam logic [7:0] RST_DAMP_LOW_GAIN  = 8'h03;  // damping factor 5
  localparam logic [7:0] RST_ZERO           = 8'h00;

  // ----------------------------------------------------------------
  // numeric limits and timing
  // ----------------------------------------------------------------
  localparam logic signed [5:0] MEAN_OFS_MAX = 6'sd13;  // 13 x 0.101 ns <= 1.4 ns
  localparam int CLK_PERIOD_NS  = 25;
  localparam int BO_HOLD_NS     = 1000;  // temporary holdover before measuring
  localparam int BO_HOLD_CYC    = (BO_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] BW_18HZ = 2'd0;
  localparam logic [1:0] BW_35HZ = 2'd1;
  localparam logic [1:0] BW_70HZ = 2'd2;
  localparam logic [2:0] DAMP_DEFAULT = 3'd3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BO_IDLE    = 2'b00,
    BO_HOLD    = 2'b01,
    BO_MEASURE = 2'b11,
    BO_APPLY   = 2'b10
  } dpc_bo_state_t;

  typedef enum logic [1:0] {
    FB_DIGITAL   = 2'd0,
    FB_ANALOG_HI = 2'd1,
    FB_ANALOG_LO = 2'd2
  } dpc_fb_t;

  typedef struct packed {
    logic [1:0] bandwidth;        // 0:18 Hz 1:35 Hz 2:70 Hz
    logic [2:0] damping;          // 1..5 -> 1.2, 2.5, 5, 10, 20
    logic       pd2_enable;
    logic [2:0] pd2_gain;
    logic       fine_loss_enable;
    logic [2:0] fine_loss_limit;
    logic       coarse_loss_enable;
    logic       coarse_capture_enable;
    logic       coarse_in_loop;
    logic [3:0] coarse_range;
    logic       noise_filter;
  } dpc_loop_cfg_t;

endpackage

// >>> dpc_ref_model.sv
// reference side model: loop update instants, sync ticks every 64 clocks, switch pulses
`timescale 1ns/100ps
module dpc_ref_model (
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  input  wire logic swap_req_i,
  output logic      loop_update_o,
  output logic      ref_switch_o,
  output logic      sync_tick_o
);
  logic [5:0] cnt_q;
  // free counter paces updates and ticks; quiet in reset so no stray pulse
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      cnt_q <= 6'h00;
      loop_update_o <= 1'b0;
      ref_switch_o <= 1'b0;
      sync_tick_o <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 6'h01;
      loop_update_o <= (cnt_q[3:0] == 4'hf);
      ref_switch_o <= swap_req_i;
      sync_tick_o <= (cnt_q == 6'h3f);
    end
  end
endmodule

// >>> tb_dpc_ctrl.sv
// self-checking bench for the phase compensation controller
`timescale 1ns/100ps
module tb_dpc_ctrl;
  import dpc_pkg::*;
  logic clock_i, rst_b_i, spi_sclk_i, spi_cs_b_i, spi_sdi_i, spi_sdo_o, swap_q;
  logic loop_locked_i, ref_switch_i, loop_update_i, at_freq_limit_i, sync_tick_8k_i;
  logic holdover_o, integral_limit_o, frame_sync_out_o, multiframe_sync_out_o;
  logic signed [15:0] ref_phase_i;
  logic signed [17:0] phase_offset_o;
  logic [7:0]         secondary_freq_sel_o, rd;
  dpc_loop_cfg_t      primary_cfg_o, secondary_cfg_o;
  dpc_fb_t            pfb = FB_DIGITAL;
  int                 n_mismatch = 0, comparisons = 0;
  logic [14:0]        rtab [5] = '{{OFS_BUILD_OUT_CTRL, 8'h08}, {OFS_DAMP_LOW_GAIN, 8'h03},
    {7'h10, 8'h00}, {OFS_STATUS_LOW, 8'h34}, {OFS_STATUS_HIGH, 8'h12}};

  dpc_ctrl dpc_ctrl_i (.clock_i, .rst_b_i, .spi_sclk_i, .spi_cs_b_i, .spi_sdi_i, .spi_sdo_o,
    .spi_sdo_oe_o(), .loop_locked_i, .ref_switch_i, .loop_update_i, .at_freq_limit_i,
    .primary_fb_i(pfb), .secondary_fb_i(FB_ANALOG_HI), .ref_phase_i,
    .primary_phase_i(16'sh1234), .secondary_phase_i(16'sh0000), .sync_tick_8k_i,
    .primary_cfg_o, .secondary_cfg_o, .holdover_o, .phase_offset_o, .integral_limit_o,
    .secondary_freq_sel_o, .diff_output_sel_o(), .secondary_digital_fb_o(),
    .frame_sync_out_o, .multiframe_sync_out_o);
  dpc_ref_model dpc_ref_model_i (.clock_i, .rst_b_i, .swap_req_i(swap_q),
    .loop_update_o(loop_update_i), .ref_switch_o(ref_switch_i), .sync_tick_o(sync_tick_8k_i));

  // 40 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask

  // one frame: read flag, address, data, msb first; sclk half period of five clocks
  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {rw, a, d};
    spi_cs_b_i = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi_i = f[i];
      cyc(5);
      spi_sclk_i = 1'b1;
      rd = {rd[6:0], spi_sdo_o};
      cyc(5);
      spi_sclk_i = 1'b0;
    end
    spi_cs_b_i = 1'b1;
    cyc(4);
  endtask

  task automatic chk(input string s, input logic [17:0] e, input logic [17:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask

  // switch the reference, look at holdover, then let the sequence and an update pass
  task automatic swap(input logic e);
    swap_q = 1'b1;
    cyc(1);
    swap_q = 1'b0;
    cyc(2);
    chk("hold", 18'(e), 18'(holdover_o));
    cyc(64);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // hang guard, far beyond the roughly 9.4k cycles the sequence needs
  initial begin
    #1ms;
    n_mismatch++;
    wrap_up();
  end

  // main sequence
  initial begin
    {spi_sclk_i, spi_sdi_i, loop_locked_i, at_freq_limit_i, swap_q, rst_b_i} = 6'h00;
    spi_cs_b_i = 1'b1;
    ref_phase_i = 16'sh0064;
    rd = 8'h00;
    cyc(16);
    rst_b_i = 1'b1;
    cyc(4);
    foreach (rtab[i]) begin
      xfer(1'b1, rtab[i][14:8], 8'h00);
      chk("read", 18'(rtab[i][7:0]), 18'(rd));
    end
    loop_locked_i = 1'b1;
    xfer(1'b0, OFS_MEAN_OFFSET, 8'h05);
    swap(1'b1);
    chk("ofs", 18'sd105, phase_offset_o);
    ref_phase_i = 16'sh012c;
    xfer(1'b0, OFS_BUILD_OUT_CTRL, 8'h0c);
    swap(1'b0);
    chk("ofs", 18'sd105, phase_offset_o);
    xfer(1'b0, OFS_BUILD_OUT_CTRL, 8'h08);
    xfer(1'b0, OFS_MEAN_OFFSET, 8'h1f);
    swap(1'b1);
    chk("ofs", 18'sd313, phase_offset_o);
    xfer(1'b0, OFS_BUILD_OUT_CTRL, 8'h00);
    for (int k = 0; k < 8000 && phase_offset_o !== 18'sd0; k++)
      cyc(1);
    chk("slew", 18'sd0, phase_offset_o);
    xfer(1'b0, OFS_BUILD_OUT_CTRL, 8'h08);
    chk("hold", 18'h1, 18'(holdover_o));
    cyc(64);
    // unlocked with the fixed policy must still use the locked bandwidth
    {loop_locked_i, at_freq_limit_i} = 2'b01;
    xfer(1'b0, OFS_BW_POLICY, 8'h08);
    xfer(1'b0, OFS_PRI_PD2_GAIN, 8'h85);
    xfer(1'b0, OFS_FINE_LOSS, 8'h86);
    xfer(1'b0, OFS_SEC_OUT_FREQ, 8'h5a);
    for (int b = 0; b < 3; b++) begin
      xfer(1'b0, OFS_LOCKED_BW, 8'(b));
      cyc(20);
      chk("bw", 18'(b), 18'(primary_cfg_o.bandwidth));
    end
    chk("cfg", 18'h0_b5bd, 18'({secondary_freq_sel_o, primary_cfg_o.pd2_enable,
      primary_cfg_o.pd2_gain, primary_cfg_o.fine_loss_enable, primary_cfg_o.fine_loss_limit,
      integral_limit_o}));
    // trim adds to the held offset, then the auxiliary build-out bit blocks it
    xfer(1'b0, OFS_TRIM_LOW, 8'h10);
    cyc(20);
    chk("trim", 18'sd329, phase_offset_o);
    xfer(1'b0, OFS_FILTER_AUX, 8'h90);
    xfer(1'b0, OFS_COARSE_CFG, 8'hc9);
    xfer(1'b0, OFS_SEC_PD2_GAIN, 8'ha0);
    pfb = FB_ANALOG_LO;
    cyc(20);
    chk("trim", 18'sd313, phase_offset_o);
    chk("coarse", 18'h0_00d3, 18'({primary_cfg_o.coarse_loss_enable,
      primary_cfg_o.coarse_capture_enable, primary_cfg_o.coarse_in_loop,
      primary_cfg_o.coarse_range, primary_cfg_o.noise_filter}));
    chk("gain", 18'h0_0003, 18'(primary_cfg_o.pd2_gain));
    chk("sec", 18'h0_0016, 18'({secondary_cfg_o.pd2_gain,
      secondary_cfg_o.fine_loss_limit}));
    xfer(1'b0, OFS_BW_POLICY, 8'h88);
    cyc(20);
    chk("bw", 18'h0, 18'(primary_cfg_o.bandwidth));
    // damping code 5 is clamped to factor code 3 at the narrowest bandwidth
    xfer(1'b0, OFS_DAMP_LOW_GAIN, 8'h05);
    cyc(20);
    chk("damp", 18'h0_0003, 18'(primary_cfg_o.damping));
    wrap_up();
  end
endmodule
